// *** inc/crf_pkg.sv ***
package crf_pkg;

    // ************************************************************
    // Widths and register addresses (APB byte offsets)
    // ************************************************************
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam logic [7:0] OFS_IPTR = 8'h00;
    localparam logic [7:0] OFS_ACC = 8'h04;
    localparam logic [7:0] OFS_TMP = 8'h08;
    localparam logic [7:0] OFS_IDX = 8'h0c;
    localparam logic [7:0] OFS_AUX = 8'h10;
    localparam logic [7:0] OFS_STK = 8'h14;
    localparam logic [7:0] OFS_PSW = 8'h18;
    localparam logic [7:0] OFS_OP = 8'h1c;
    localparam logic [7:0] OFS_RES = 8'h20;
    localparam logic [7:0] OFS_ADDR = 8'h24;
    localparam logic [7:0] OFS_REGION = 8'h28;
    localparam logic [7:0] OFS_IRQ = 8'h2c;
    localparam logic [7:0] OFS_GPR = 8'h30;

    // ************************************************************
    // Condition code bit positions
    // ************************************************************
    localparam int unsigned CC_H = 7;
    localparam int unsigned CC_I = 6;
    localparam int unsigned CC_IL1 = 5;
    localparam int unsigned CC_IL0 = 4;
    localparam int unsigned CC_N = 3;
    localparam int unsigned CC_Z = 2;
    localparam int unsigned CC_V = 1;
    localparam int unsigned CC_C = 0;
    localparam logic [7:0] CCR_RST = 8'h30;
    localparam logic [7:0] BANK_RST = 8'h00;
    localparam logic [1:0] LEVEL_NONE = 2'h3;

    // ************************************************************
    // Memory regions
    // ************************************************************
    localparam logic [15:0] IO_LAST = 16'h007f;
    localparam logic [15:0] DIR_FIRST = 16'h0080;
    localparam logic [15:0] DIR_LAST = 16'h00ff;
    localparam logic [15:0] GPR_FIRST = 16'h0100;
    localparam logic [15:0] GPR_LAST = 16'h01ff;
    localparam logic [15:0] VEC_FIRST = 16'hffc0;
    localparam int unsigned BANK_W = 5;
    localparam int unsigned REG_W = 3;
    localparam int unsigned GPR_N = 256;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        OP_NONE, OP_ADD, OP_SUB, OP_SHL, OP_SHR
    } crf_op_t;

    typedef enum logic [2:0] {
        RG_IO, RG_DIRECT, RG_GPR, RG_VECTOR, RG_OTHER
    } crf_region_t;

    typedef struct packed {
        logic [7:0] bank;
        logic [7:0] condition_code_byte;
    } crf_psw_t;

    typedef struct packed {
        logic [15:0] iptr;
        logic [15:0] acc;
        logic [15:0] tmp;
        logic [15:0] idx;
        logic [15:0] aux;
        logic [15:0] stk;
        crf_psw_t psw;
        logic [7:0] res;
        logic [15:0] addr;
        logic [1:0] req_level;
        logic irq_take;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } crf_state_t;

endpackage : crf_pkg

// *** sim/crf_core_assertions.sv ***
`timescale 1ns/1ps
// ****
// Port checks
// ****
module crf_core_assertions
    import crf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Interrupt and status
    input wire logic irq_valid_i,
    input wire logic [1:0] irq_level_i,
    input wire logic irq_accept_o,
    input wire logic [15:0] instruction_pointer_o,
    input wire logic [15:0] program_status_word_o
);
    logic [7:0] cc;
    assign cc = program_status_word_o[7:0];
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_ready_bound: assert property (psel_i && penable_i && !pready_o
        |-> ##[0:2] pready_o) else $error("access not answered");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_irq_take: assert property (
        irq_valid_i && cc[6] && cc[5:4] != 2'h3
        && irq_level_i < cc[5:4] |=> irq_accept_o)
        else $error("request not accepted");
    a_irq_mask: assert property (
        !cc[6] || cc[5:4] == 2'h3 || !irq_valid_i |=> !irq_accept_o)
        else $error("masked request accepted");
    a_irq_level: assert property (
        irq_valid_i && irq_level_i >= cc[5:4] |=> !irq_accept_o)
        else $error("low priority request accepted");
    // Checked through reset itself, so no disable
    a_reset_status: assert property (disable iff (1'b0)
        rst_i |=> program_status_word_o == 16'h0030)
        else $error("status word wrong after reset");
    a_psw_write: assert property (
        !$past(rst_i) && $changed(program_status_word_o)
        |-> $past(psel_i && penable_i && pwrite_i))
        else $error("status word changed without write");
    a_iptr_write: assert property (
        !$past(rst_i) && $changed(instruction_pointer_o)
        |-> $past(psel_i && penable_i && pwrite_i))
        else $error("pointer changed without write");
    c_accept: cover property (irq_accept_o);
    c_error: cover property (pslverr_o);
    c_write: cover property (pready_o && pwrite_i);
    c_blocked: cover property (irq_valid_i && cc[5:4] == 2'h3);
endmodule : crf_core_assertions

// *** sim/crf_core_tb_top.sv ***
`timescale 1ns/1ps
// ****
// Bench
// ****
module crf_core_tb_top import crf_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pw = 1'b0;
    logic irqv = 1'b0;
    logic [1:0] irql = 2'h0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic perr;
    logic take;
    logic [15:0] ip;
    logic [15:0] psw;
    logic [31:0] rdat;
    logic rerr;
    logic [15:0] v;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    // {a, t, op, result, flags}
    logic [39:0] alu[8] = '{40'h0808011080, 40'h7f0101808a,
        40'hff01010085, 40'h1001020f80, 40'h000102ff89,
        40'h8001027f82, 40'h8100030283, 40'h0100040087};
    // {probe address, region}
    logic [19:0] rg[10] = '{20'h00000, 20'h007f0, 20'h00801, 20'h00ff1,
        20'h01002, 20'h01ff2, 20'h02004, 20'hffbf4, 20'hffc03, 20'hffff3};
    // {flags, level, accepted}
    logic [10:0] iq[5] = '{{8'h60, 2'h1, 1'b1}, {8'h60, 2'h2, 1'b0},
        {8'h70, 2'h0, 1'b0}, {8'h20, 2'h0, 1'b0}, {8'h60, 2'h0, 1'b1}};
    crf_core dut (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pwd),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
        .irq_valid_i(irqv), .irq_level_i(irql), .irq_accept_o(take),
        .instruction_pointer_o(ip), .program_status_word_o(psw));
    always #2 clk = ~clk;
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_flag(input string nm, input logic e, g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %b got %b", nm, e, g);
        end
    endtask : chk_flag
    // Held until ready is seen at a rising edge, released after it
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pw <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : xfer
    task automatic rchk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask : rchk
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("psw", 32'h30, {16'h0, psw});
        for (int i = 0; i < 6; i++) begin
            v = 16'(16'h1111 * (i + 1));
            xfer(1'b1, 8'(4 * i), {16'hffff, v});
            rchk("reg", 8'(4 * i), {16'h0, v});
        end
        chk("iptr", 32'h1111, {16'h0, ip});
        xfer(1'b1, OFS_PSW, 32'h1f00);
        rchk("psw", OFS_PSW, 32'h1f00);
        xfer(1'b1, OFS_GPR + 8'h1c, 32'h5a);
        xfer(1'b1, OFS_PSW, 32'h0500);
        xfer(1'b1, OFS_GPR + 8'h1c, 32'ha5);
        rchk("gpr", OFS_GPR + 8'h1c, 32'ha5);
        xfer(1'b1, OFS_PSW, 32'h1f00);
        rchk("gpr", OFS_GPR + 8'h1c, 32'h5a);
        xfer(1'b1, OFS_PSW, 32'h0);
        foreach (alu[i]) begin
            xfer(1'b1, OFS_ACC, {16'h0, 8'h12, alu[i][39:32]});
            xfer(1'b1, OFS_TMP, {16'h0, 8'h34, alu[i][31:24]});
            xfer(1'b1, OFS_OP, {24'h0, alu[i][23:16]});
            rchk("acc", OFS_ACC, {16'h0, 8'h12, alu[i][15:8]});
            rchk("tmp", OFS_TMP, {16'h0, 8'h34, alu[i][31:24]});
            // Half carry is meaningless for shifts
            if (alu[i][23:16] < 8'h03) begin
                chk_flag("h", alu[i][CC_H], psw[CC_H]);
            end
            chk_flag("n", alu[i][CC_N], psw[CC_N]);
            chk_flag("z", alu[i][CC_Z], psw[CC_Z]);
            chk_flag("v", alu[i][CC_V], psw[CC_V]);
            chk_flag("c", alu[i][CC_C], psw[CC_C]);
        end
        // Unused op code leaves the accumulator alone
        xfer(1'b1, OFS_OP, 32'h0);
        rchk("acc", OFS_ACC, {16'h0, 8'h12, 8'h00});
        foreach (rg[i]) begin
            xfer(1'b1, OFS_ADDR, {16'h0, rg[i][19:4]});
            rchk("rg", OFS_REGION, {28'h0, rg[i][3:0]});
        end
        xfer(1'b0, 8'h50, 32'h0);
        chk("err", 32'h1, {31'h0, rerr});
        xfer(1'b1, 8'h02, 32'h0);
        chk("err", 32'h1, {31'h0, rerr});
        xfer(1'b1, OFS_RES, 32'h55);
        chk("err", 32'h0, {31'h0, rerr});
        rchk("res", OFS_RES, 32'h0);
        foreach (iq[i]) begin
            xfer(1'b1, OFS_PSW, {24'h0, iq[i][10:3]});
            irqv <= 1'b1;
            irql <= iq[i][2:1];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("accept", {31'h0, iq[i][0]}, {31'h0, take});
            rchk("irq", OFS_IRQ, {29'h0, iq[i][2:0]});
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("psw", 32'h30, {16'h0, psw});
        chk_flag("accept", 1'b0, take);
        give_verdict();
    end
endmodule : crf_core_tb_top
bind crf_core crf_core_assertions u_chk (.ref_clk_i, .rst_i, .psel_i,
    .penable_i, .pwrite_i, .pready_o, .pslverr_o, .irq_valid_i,
    .irq_level_i, .irq_accept_o, .instruction_pointer_o,
    .program_status_word_o);

// *** src/crf_core.sv ***
`timescale 1ns/1ps
module crf_core
    import crf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Interrupt request level input
    input wire logic irq_valid_i,
    input wire logic [1:0] irq_level_i,
    // Status outputs
    output logic irq_accept_o,
    output logic [15:0] instruction_pointer_o,
    output logic [15:0] program_status_word_o
);

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic crf_region_t region_of(input logic [15:0] a);
        if (a <= IO_LAST) begin
            region_of = RG_IO;
        end else if (a >= DIR_FIRST && a <= DIR_LAST) begin
            region_of = RG_DIRECT;
        end else if (a >= GPR_FIRST && a <= GPR_LAST) begin
            region_of = RG_GPR;
        end else if (a >= VEC_FIRST) begin
            region_of = RG_VECTOR;
        end else begin
            region_of = RG_OTHER;
        end
    endfunction : region_of

    // Register slot index within the backing area, bank bits above r
    function automatic logic [7:0] gpr_index(input logic [7:0] bank,
                                             input logic [2:0] r);
        gpr_index = {bank[BANK_W-1:0], r};
    endfunction : gpr_index

    // Level 0 highest; accept only strictly higher priority
    function automatic logic may_accept(input logic [7:0] condition_code_byte,
                                        input logic [1:0] lvl);
        logic [1:0] cur;
        cur = condition_code_byte[CC_IL1:CC_IL0];
        may_accept = condition_code_byte[CC_I] && cur != LEVEL_NONE
                     && lvl < cur;
    endfunction : may_accept

    // ************************************************************
    // State
    // ************************************************************
    crf_state_t s_q;
    crf_state_t s_d;
    // Backing RAM is left uninitialised on purpose
    logic [7:0] gpr_mem [GPR_N];
    logic gpr_we;
    logic [7:0] gpr_wa;
    logic [7:0] gpr_wd;
    logic [7:0] gpr_off;

    logic apb_acc;
    logic [7:0] a8;
    logic [7:0] t8;
    logic [8:0] sum9;
    logic [4:0] half5;
    logic [7:0] r8;
    logic [31:0] rd;
    logic addr_ok;

    assign apb_acc = psel_i && penable_i && !s_q.pready;

    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.irq_take = irq_valid_i && may_accept(s_q.psw.condition_code_byte, irq_level_i);
        s_d.req_level = irq_level_i;
        gpr_we = 1'b0;
        // Offset from the first register slot picks r
        gpr_off = paddr_i - OFS_GPR;
        gpr_wa = gpr_index(s_q.psw.bank, gpr_off[4:2]);
        gpr_wd = pwdata_i[7:0];
        a8 = s_q.acc[7:0];
        t8 = s_q.tmp[7:0];
        sum9 = 9'h000;
        half5 = 5'h00;
        r8 = 8'h00;
        rd = 32'h0000_0000;
        addr_ok = 1'b1;
        // Read mux
        unique case (paddr_i)
            OFS_IPTR: rd = {16'h0000, s_q.iptr};
            OFS_ACC: rd = {16'h0000, s_q.acc};
            OFS_TMP: rd = {16'h0000, s_q.tmp};
            OFS_IDX: rd = {16'h0000, s_q.idx};
            OFS_AUX: rd = {16'h0000, s_q.aux};
            OFS_STK: rd = {16'h0000, s_q.stk};
            OFS_PSW: rd = {16'h0000, s_q.psw};
            OFS_RES: rd = {24'h000000, s_q.res};
            OFS_ADDR: rd = {16'h0000, s_q.addr};
            OFS_REGION: rd = {29'h0, region_of(s_q.addr)};
            OFS_IRQ: rd = {29'h0, s_q.req_level, s_q.irq_take};
            // Op port is write-only; must not fall into the error path
            OFS_OP: rd = 32'h0000_0000;
            default: begin
                if (paddr_i >= OFS_GPR) begin
                    rd = {24'h000000, gpr_mem[gpr_wa]};
                end else begin
                    addr_ok = 1'b0;
                end
            end
        endcase
        if (paddr_i[1:0] != 2'b00 || paddr_i > OFS_GPR + 8'h1c) begin
            addr_ok = 1'b0;
        end
        if (apb_acc) begin
            s_d.pready = 1'b1;
            s_d.pslverr = !addr_ok;
            s_d.prdata = addr_ok ? rd : 32'h0000_0000;
            if (pwrite_i && addr_ok) begin
                unique case (paddr_i)
                    OFS_IPTR: s_d.iptr = pwdata_i[15:0];
                    OFS_ACC: s_d.acc = pwdata_i[15:0];
                    OFS_TMP: s_d.tmp = pwdata_i[15:0];
                    OFS_IDX: s_d.idx = pwdata_i[15:0];
                    OFS_AUX: s_d.aux = pwdata_i[15:0];
                    OFS_STK: s_d.stk = pwdata_i[15:0];
                    OFS_PSW: s_d.psw = pwdata_i[15:0];
                    OFS_ADDR: s_d.addr = pwdata_i[15:0];
                    OFS_OP: begin
                        // Byte op on low bytes; high byte untouched
                        unique case (crf_op_t'(pwdata_i[2:0]))
                            OP_ADD: begin
                                sum9 = {1'b0, a8} + {1'b0, t8};
                                half5 = {1'b0, a8[3:0]} + {1'b0, t8[3:0]};
                                r8 = sum9[7:0];
                                s_d.psw.condition_code_byte[CC_V] = (a8[7] == t8[7])
                                    && (r8[7] != a8[7]);
                            end
                            OP_SUB: begin
                                sum9 = {1'b0, a8} - {1'b0, t8};
                                half5 = {1'b0, a8[3:0]} - {1'b0, t8[3:0]};
                                r8 = sum9[7:0];
                                s_d.psw.condition_code_byte[CC_V] = (a8[7] != t8[7])
                                    && (r8[7] != a8[7]);
                            end
                            OP_SHL: begin
                                r8 = {a8[6:0], 1'b0};
                                sum9 = {a8[7], r8};
                            end
                            OP_SHR: begin
                                r8 = {1'b0, a8[7:1]};
                                sum9 = {a8[0], r8};
                            end
                            default: r8 = a8;
                        endcase
                        if (crf_op_t'(pwdata_i[2:0]) inside
                            {OP_ADD, OP_SUB, OP_SHL, OP_SHR}) begin
                            s_d.acc[7:0] = r8;
                            s_d.res = r8;
                            s_d.psw.condition_code_byte[CC_C] = sum9[8];
                            s_d.psw.condition_code_byte[CC_N] = r8[7];
                            s_d.psw.condition_code_byte[CC_Z] = r8 == 8'h00;
                        end
                        if (crf_op_t'(pwdata_i[2:0]) inside
                            {OP_ADD, OP_SUB}) begin
                            s_d.psw.condition_code_byte[CC_H] = half5[4];
                        end
                    end
                    default: begin
                        gpr_we = paddr_i >= OFS_GPR;
                    end
                endcase
            end
        end
        if (rst_i) begin
            s_d = '0;
            s_d.psw.condition_code_byte = CCR_RST;
            s_d.psw.bank = BANK_RST;
            gpr_we = 1'b0;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        s_q <= s_d;
    end

    always_ff @(posedge ref_clk_i) begin
        if (gpr_we) begin
            gpr_mem[gpr_wa] <= gpr_wd;
        end
    end

    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign irq_accept_o = s_q.irq_take;
    assign instruction_pointer_o = s_q.iptr;
    assign program_status_word_o = s_q.psw;

endmodule : crf_core
